//--- logic/mmd_decoder.sv
/*
  Decoder end: classifies each access, serves flash, mirror and RAM from
  arrays, and passes peripheral accesses to a plain user-side port.
  Assumes the core holds a request until ack and issues at most one at a time.
*/
`timescale 1ns/1ps
module mmd_decoder #(
  parameter bit BIG = 1'b0
) (
  input wire clk,
  input wire reset,
  mmd_if.decoder bus,
  output logic periph_sel,
  output logic periph_ext,
  output logic periph_we,
  output logic [10:0] periph_addr,
  output logic [7:0] periph_wdata,
  input wire [7:0] periph_rdata,
  input wire flash_we,
  input wire [12:0] flash_waddr,
  input wire [7:0] flash_wdata
);

  // ****************************************************************
  // Region map
  // ****************************************************************
  localparam int FLASH_N = BIG ? 8192 : 4096;
  localparam int RAM_N = BIG ? 1024 : 512;
  localparam logic [19:0] FLASH_TOP =
    BIG ? mmd_pkg::FLASH_HI_8K : mmd_pkg::FLASH_HI_4K;
  localparam logic [19:0] MIRROR_TOP =
    BIG ? mmd_pkg::MIRROR_HI_8K : mmd_pkg::MIRROR_HI_4K;
  localparam logic [19:0] RAM_BASE =
    BIG ? mmd_pkg::RAM_LO_1K : mmd_pkg::RAM_LO_512;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic illegal;
    mmd_pkg::mmd_region_t region;
  } mmd_dec_state_t;

  mmd_dec_state_t st_reg, st_next;
  logic [7:0] flash_mem [FLASH_N];
  logic [7:0] ram_mem [RAM_N];
  mmd_pkg::mmd_region_t reg_hit;
  logic [19:0] a;
  logic [12:0] flash_off;
  logic [19:0] ram_off;
  logic bad;

  // ****************************************************************
  // Classification
  // ****************************************************************
  always_comb begin
    a = bus.addr;
    if (a <= mmd_pkg::VEC_HI) begin
      reg_hit = mmd_pkg::MMD_REG_VECTOR;
    end else if (a >= mmd_pkg::TABLE_CALL_INSTRUCTION_LO && a <= mmd_pkg::TABLE_CALL_INSTRUCTION_HI) begin
      reg_hit = mmd_pkg::MMD_REG_TABLE_CALL_INSTRUCTION;
    end else if (a >= mmd_pkg::OPT_LO && a <= mmd_pkg::OPT_HI) begin
      reg_hit = mmd_pkg::MMD_REG_OPTION;
    end else if ((a >= mmd_pkg::DBG0_LO && a <= mmd_pkg::DBG0_HI) ||
        (BIG && a >= mmd_pkg::DBG1_LO && a <= mmd_pkg::DBG1_HI)) begin
      reg_hit = mmd_pkg::MMD_REG_DEBUG_ID;
    end else if (a <= FLASH_TOP) begin
      reg_hit = mmd_pkg::MMD_REG_FLASH;
    end else if (a >= mmd_pkg::SFR2_LO && a <= mmd_pkg::SFR2_HI) begin
      reg_hit = mmd_pkg::MMD_REG_SFR2;
    end else if (a >= mmd_pkg::MIRROR_LO && a <= MIRROR_TOP) begin
      reg_hit = mmd_pkg::MMD_REG_MIRROR;
    end else if (a >= RAM_BASE && a <= mmd_pkg::RAM_HI) begin
      reg_hit = mmd_pkg::MMD_REG_RAM;
    end else if (a >= mmd_pkg::GPR_LO && a <= mmd_pkg::GPR_HI) begin
      reg_hit = mmd_pkg::MMD_REG_GPR;
    end else if (a >= mmd_pkg::SFR_LO) begin
      reg_hit = mmd_pkg::MMD_REG_SFR;
    end else begin
      reg_hit = mmd_pkg::MMD_REG_RESERVED;
    end
  end

  // Flash and mirror share the low offset bits; the mirror is just the
  // flash seen at another base.
  assign flash_off = a[12:0] & 13'(FLASH_N - 1);
  assign ram_off = a - RAM_BASE;

  // ****************************************************************
  // Legality and answer
  // ****************************************************************
  always_comb begin
    bad = 1'b0;
    if (reg_hit == mmd_pkg::MMD_REG_RESERVED) begin
      bad = 1'b1;
    end else if (bus.kind == mmd_pkg::MMD_ACC_FETCH &&
        (reg_hit == mmd_pkg::MMD_REG_MIRROR ||
         reg_hit == mmd_pkg::MMD_REG_GPR)) begin
      bad = 1'b1;
    end else if (bus.kind == mmd_pkg::MMD_ACC_WRITE &&
        reg_hit == mmd_pkg::MMD_REG_MIRROR) begin
      bad = 1'b1;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.ack = bus.req && !st_reg.ack;
    periph_sel = 1'b0;
    periph_ext = 1'b0;
    periph_we = 1'b0;
    periph_addr = a[10:0];
    periph_wdata = bus.wdata;
    if (bus.req && !st_reg.ack) begin
      st_next.region = reg_hit;
      st_next.illegal = bad;
      st_next.rdata = 8'h00;
      if (!bad && bus.kind != mmd_pkg::MMD_ACC_WRITE) begin
        case (reg_hit)
          mmd_pkg::MMD_REG_RAM: st_next.rdata = ram_mem[ram_off[9:0]];
          mmd_pkg::MMD_REG_SFR,
          mmd_pkg::MMD_REG_SFR2,
          mmd_pkg::MMD_REG_GPR: st_next.rdata = periph_rdata;
          default: st_next.rdata = flash_mem[flash_off];
        endcase
      end
      if (!bad && (reg_hit == mmd_pkg::MMD_REG_SFR ||
          reg_hit == mmd_pkg::MMD_REG_SFR2 ||
          reg_hit == mmd_pkg::MMD_REG_GPR)) begin
        periph_sel = 1'b1;
        periph_ext = reg_hit == mmd_pkg::MMD_REG_SFR2;
        periph_we = bus.kind == mmd_pkg::MMD_ACC_WRITE;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Memories
  // ****************************************************************
  // Writes to flash, mirror and illegal targets are suppressed here;
  // flash is loaded only by the side port.
  always_ff @(posedge clk) begin
    if (bus.req && !st_reg.ack && !bad &&
        bus.kind == mmd_pkg::MMD_ACC_WRITE &&
        reg_hit == mmd_pkg::MMD_REG_RAM) begin
      ram_mem[ram_off[9:0]] <= bus.wdata;
    end
    if (flash_we) begin
      flash_mem[flash_we ? flash_waddr & 13'(FLASH_N - 1) : 13'h0000]
        <= flash_wdata;
    end
  end

  assign bus.ack = st_reg.ack;
  assign bus.rdata = st_reg.rdata;
  assign bus.illegal = st_reg.illegal;
  assign bus.region = st_reg.region;

endmodule

//--- logic/mmd_pkg.sv
/*
  Constants, region codes and state type for the memory map decoder.
  Assumes a single 40 MHz clock and an active-high asynchronous reset.
*/
// What this block does
// - Classify every 20-bit address into one region
// - 00000H..0007FH is the vector table
// - Vector targets limited to low 64 KB
// - Even byte low, odd byte high
// - Reset sources use 00000H, watchdog 00004H, break 0007EH
// - 00080H..000BFH is the table-call table
// - 000C0H..000C3H is the option byte area
// - Debug ID areas at 000C4H and 010C4H
// - Code flash is 4 KB or 8 KB
// - Mirror reads return flash at same offset
// - Mirror is read-only, never fetched
// - RAM is 512 bytes or 1 KB
// - RAM allows read, write, fetch, stack
// - Core never fetches or stacks in register window; the core passes window fetches and the decoder flags them
// - FFF00H upward is primary peripheral area
// - F0000H..F07FFH is extended peripheral area
// - Core never touches reserved ranges; the core passes such requests and the decoder flags them
// - Core never touches unassigned peripheral addresses; the core passes such requests and the decoder does not flag them
// - Data bank register resets to 0FH
// - Stack pointer only points into RAM
package mmd_pkg;

  localparam int ADDR_W = 20;
  localparam logic [19:0] VEC_LO = 20'h00000;
  localparam logic [19:0] VEC_HI = 20'h0007F;
  localparam logic [19:0] VEC_RESET = 20'h00000;
  localparam logic [19:0] VEC_WDT_IRQ = 20'h00004;
  localparam logic [19:0] VEC_BREAK = 20'h0007E;
  localparam logic [19:0] VEC_OTHER_LO = 20'h00006;
  localparam logic [19:0] TABLE_CALL_INSTRUCTION_LO = 20'h00080;
  localparam logic [19:0] TABLE_CALL_INSTRUCTION_HI = 20'h000BF;
  localparam logic [19:0] OPT_LO = 20'h000C0;
  localparam logic [19:0] OPT_HI = 20'h000C3;
  localparam logic [19:0] DBG0_LO = 20'h000C4;
  localparam logic [19:0] DBG0_HI = 20'h000CD;
  localparam logic [19:0] DBG1_LO = 20'h010C4;
  localparam logic [19:0] DBG1_HI = 20'h010CD;
  localparam logic [19:0] FLASH_HI_4K = 20'h00FFF;
  localparam logic [19:0] FLASH_HI_8K = 20'h01FFF;
  localparam logic [19:0] MIRROR_LO = 20'hF8000;
  localparam logic [19:0] MIRROR_HI_4K = 20'hF8FFF;
  localparam logic [19:0] MIRROR_HI_8K = 20'hF9FFF;
  localparam logic [19:0] RAM_LO_512 = 20'hFFCE0;
  localparam logic [19:0] RAM_LO_1K = 20'hFFAE0;
  localparam logic [19:0] RAM_HI = 20'hFFEDF;
  localparam logic [19:0] GPR_LO = 20'hFFEF8;
  localparam logic [19:0] GPR_HI = 20'hFFEFF;
  localparam logic [19:0] SFR_LO = 20'hFFF00;
  localparam logic [19:0] SFR2_LO = 20'hF0000;
  localparam logic [19:0] SFR2_HI = 20'hF07FF;
  localparam logic [19:0] LOW64K_MASK = 20'h0FFFF;
  localparam logic [3:0] BANK_RESET = 4'hF;

  typedef enum logic [3:0] {
    MMD_REG_RESERVED,
    MMD_REG_VECTOR,
    MMD_REG_TABLE_CALL_INSTRUCTION,
    MMD_REG_OPTION,
    MMD_REG_DEBUG_ID,
    MMD_REG_FLASH,
    MMD_REG_MIRROR,
    MMD_REG_RAM,
    MMD_REG_GPR,
    MMD_REG_SFR,
    MMD_REG_SFR2
  } mmd_region_t;

  typedef enum logic [1:0] {
    MMD_ACC_READ,
    MMD_ACC_WRITE,
    MMD_ACC_FETCH
  } mmd_acc_t;

  typedef enum logic [1:0] {
    MMD_SRC_RESET,
    MMD_SRC_WDT_IRQ,
    MMD_SRC_BREAK,
    MMD_SRC_IRQ
  } mmd_vsrc_t;

  typedef enum {
    MMD_CORE_IDLE,
    MMD_CORE_VEC_LO,
    MMD_CORE_VEC_HI,
    MMD_CORE_ACCESS
  } mmd_core_state_t;

endpackage

//--- logic/mmd_if.sv
/*
  Link between the core end and the decoder end.
  Assumes both ends share clk and reset.
*/
`timescale 1ns/1ps
interface mmd_if;
  logic req;
  mmd_pkg::mmd_acc_t kind;
  logic [19:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic illegal;
  mmd_pkg::mmd_region_t region;

  modport decoder (
    input req, kind, addr, wdata,
    output ack, rdata, illegal, region
  );
  modport core (
    output req, kind, addr, wdata,
    input ack, rdata, illegal, region
  );
endinterface

//--- logic/mmd_core.sv
/*
  Core end: issues single-byte accesses, builds data addresses from the
  bank register, and loads 16-bit vectors from two table bytes.
  Assumes the decoder answers each request with a one-cycle ack.
*/
`timescale 1ns/1ps
module mmd_core (
  input wire clk,
  input wire reset,
  mmd_if.core bus,
  input wire vec_start,
  input wire [1:0] vec_src,
  input wire [4:0] vec_irq_idx,
  input wire acc_start,
  input wire [1:0] acc_kind,
  input wire acc_banked,
  input wire [19:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire bank_we,
  input wire [3:0] bank_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic [19:0] vec_target,
  output logic illegal,
  output logic [3:0] data_bank_register
);

  typedef struct packed {
    mmd_pkg::mmd_core_state_t state;
    logic req;
    mmd_pkg::mmd_acc_t kind;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    logic [19:0] target;
    logic illegal;
    logic [3:0] bank;
  } mmd_core_st_t;

  mmd_core_st_t st_reg, st_next;
  logic [19:0] vaddr;

  // ****************************************************************
  // Vector address
  // ****************************************************************
  always_comb begin
    case (mmd_pkg::mmd_vsrc_t'(vec_src))
      mmd_pkg::MMD_SRC_RESET: vaddr = mmd_pkg::VEC_RESET;
      mmd_pkg::MMD_SRC_WDT_IRQ: vaddr = mmd_pkg::VEC_WDT_IRQ;
      mmd_pkg::MMD_SRC_BREAK: vaddr = mmd_pkg::VEC_BREAK;
      default: vaddr = mmd_pkg::VEC_OTHER_LO + {14'h0000, vec_irq_idx, 1'b0};
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // The caller keeps the far-side rules: no access to reserved or
  // unassigned peripheral addresses and no fetch from the register
  // window. Requests pass through unchecked; the decoder flags reserved
  // addresses and window fetches but not unassigned peripheral addresses.
  // This end keeps no stack, so no frame ever leaves RAM.
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (bank_we) begin
      st_next.bank = bank_wdata;
    end
    case (st_reg.state)
      mmd_pkg::MMD_CORE_IDLE: begin
        if (vec_start) begin
          st_next.req = 1'b1;
          st_next.kind = mmd_pkg::MMD_ACC_READ;
          st_next.addr = vaddr & mmd_pkg::VEC_HI;
          st_next.state = mmd_pkg::MMD_CORE_VEC_LO;
        end else if (acc_start) begin
          st_next.req = 1'b1;
          st_next.kind = mmd_pkg::mmd_acc_t'(acc_kind);
          st_next.addr = acc_banked ?
            {st_reg.bank, acc_addr[15:0]} : acc_addr;
          st_next.wdata = acc_wdata;
          st_next.state = mmd_pkg::MMD_CORE_ACCESS;
        end
      end
      mmd_pkg::MMD_CORE_VEC_LO: begin
        if (bus.ack) begin
          st_next.target[7:0] = bus.rdata;
          st_next.addr = st_reg.addr + 20'h00001;
          st_next.req = 1'b0;
          st_next.state = mmd_pkg::MMD_CORE_VEC_HI;
        end
      end
      mmd_pkg::MMD_CORE_VEC_HI: begin
        st_next.req = !bus.ack;
        if (bus.ack) begin
          st_next.target[15:8] = bus.rdata;
          st_next.target[19:16] = 4'h0;
          st_next.done = 1'b1;
          st_next.illegal = bus.illegal;
          st_next.state = mmd_pkg::MMD_CORE_IDLE;
        end
      end
      default: begin
        if (bus.ack) begin
          st_next.req = 1'b0;
          st_next.rdata = bus.rdata;
          st_next.illegal = bus.illegal;
          st_next.done = 1'b1;
          st_next.state = mmd_pkg::MMD_CORE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= '{state: mmd_pkg::MMD_CORE_IDLE, req: 1'b0,
        kind: mmd_pkg::MMD_ACC_READ, addr: 20'h00000, wdata: 8'h00,
        done: 1'b0, rdata: 8'h00, target: 20'h00000, illegal: 1'b0,
        bank: mmd_pkg::BANK_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.req = st_reg.req;
  assign bus.kind = st_reg.kind;
  assign bus.addr = st_reg.addr;
  assign bus.wdata = st_reg.wdata;
  assign busy = st_reg.state != mmd_pkg::MMD_CORE_IDLE;
  assign done = st_reg.done;
  assign rdata = st_reg.rdata;
  assign vec_target = st_reg.target;
  assign illegal = st_reg.illegal;
  assign data_bank_register = st_reg.bank;

endmodule

//--- testbench/mmd_properties.sv
/*
  Link checker for the memory map decoder, fed with the link's signals.
  Assumes one clock and an active-high asynchronous reset for both ends.
*/
`timescale 1ns/1ps
module mmd_properties #(
  parameter bit BIG = 1'b0
) (
  input wire clk,
  input wire reset,
  input wire req,
  input mmd_pkg::mmd_acc_t kind,
  input wire [19:0] addr,
  input wire [7:0] wdata,
  input wire ack,
  input wire [7:0] rdata,
  input wire illegal,
  input mmd_pkg::mmd_region_t region
);
  // ****************************************
  // Link properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  localparam logic [19:0] MIR_HI = BIG ? mmd_pkg::MIRROR_HI_8K
                                       : mmd_pkg::MIRROR_HI_4K;
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  AST_ANSWER: assert property (s_take |=> s_answer)
    else $error("ack is not one pulse one cycle after the request");
  AST_HOLD: assert property (s_take |=> $stable(addr) && $stable(kind))
    else $error("request changed before its answer");
  AST_ILL_ZERO: assert property (ack && illegal |-> rdata == 8'h00)
    else $error("refused access returned data");
  AST_RES_ILL: assert property (
    ack && region == mmd_pkg::MMD_REG_RESERVED |-> illegal)
    else $error("reserved access not flagged");
  AST_MIR_RO: assert property (
    ack && region == mmd_pkg::MMD_REG_MIRROR
    && kind != mmd_pkg::MMD_ACC_READ |-> illegal)
    else $error("mirror write or fetch not flagged");
  AST_WIN_FETCH: assert property (
    ack && region == mmd_pkg::MMD_REG_GPR && kind == mmd_pkg::MMD_ACC_FETCH
    |-> illegal)
    else $error("register window fetch not flagged");
  AST_RAM_OK: assert property (
    ack && region == mmd_pkg::MMD_REG_RAM |-> !illegal)
    else $error("RAM access flagged");
  AST_VEC: assert property (
    ack && addr <= mmd_pkg::VEC_HI |-> region == mmd_pkg::MMD_REG_VECTOR)
    else $error("vector area misclassified");
  AST_PRIMARY: assert property (
    ack && addr >= mmd_pkg::SFR_LO |-> region == mmd_pkg::MMD_REG_SFR)
    else $error("primary peripheral area misclassified");
  AST_EXT: assert property (
    ack && addr >= mmd_pkg::SFR2_LO && addr <= mmd_pkg::SFR2_HI
    |-> region == mmd_pkg::MMD_REG_SFR2)
    else $error("extended peripheral area misclassified");
  AST_MIRROR: assert property (
    ack && addr >= mmd_pkg::MIRROR_LO && addr <= MIR_HI
    |-> region == mmd_pkg::MMD_REG_MIRROR)
    else $error("mirror area misclassified");
endmodule

//--- testbench/tb_memory_map_decoder.sv
/*
  Testbench joining the core end and the decoder end (8 KB variant).
  Assumes the peripheral side answers every read with a fixed byte.
*/
`timescale 1ns/1ps
module tb_memory_map_decoder;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic vec_start = 1'b0;
  logic [1:0] vec_src = 2'h0;
  logic acc_start = 1'b0;
  logic [1:0] acc_kind = 2'h0;
  logic acc_banked = 1'b0;
  logic [19:0] acc_addr = 20'h00000;
  logic [7:0] acc_wdata = 8'h00;
  logic bank_we = 1'b0;
  logic [3:0] bank_wdata = 4'h0;
  logic flash_we = 1'b0;
  logic [12:0] flash_waddr = 13'h0000;
  logic [7:0] flash_wdata = 8'h00;
  logic busy, done, illegal, p_sel, p_ext, p_we, ext_cap, we_cap;
  logic [7:0] rdata, p_wdata, wd_cap;
  logic [19:0] vec_target;
  logic [3:0] bank_q, reg_cap;
  logic [10:0] p_addr, ad_cap;
  int miscompares = 0;
  int checks = 0;
  // Region code in the top nibble, address below it.
  localparam logic [23:0] MAP [22] = '{24'h100000, 24'h10007F,
    24'h200080, 24'h2000BF, 24'h3000C0, 24'h3000C3, 24'h4000C4,
    24'h4000CD, 24'h4010C4, 24'h5000CE, 24'h501FFF, 24'h002000,
    24'hAF0000, 24'hAF07FF, 24'h0F0800, 24'h6F9FFF, 24'h0FA000,
    24'h7FFAE0, 24'h0FFADF, 24'h0FFEE0, 24'h8FFEF8, 24'h9FFFFF};
  mmd_if bus ();
  mmd_core mmd_core_i (.clk(clk), .reset(reset), .bus(bus.core),
    .vec_start(vec_start), .vec_src(vec_src), .vec_irq_idx(5'h02),
    .acc_start(acc_start), .acc_kind(acc_kind), .acc_banked(acc_banked),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .bank_we(bank_we),
    .bank_wdata(bank_wdata), .busy(busy), .done(done), .rdata(rdata),
    .vec_target(vec_target), .illegal(illegal),
    .data_bank_register(bank_q));
  mmd_decoder #(.BIG(1'b1)) mmd_decoder_i (.clk(clk), .reset(reset),
    .bus(bus.decoder), .periph_sel(p_sel), .periph_ext(p_ext),
    .periph_we(p_we), .periph_addr(p_addr), .periph_wdata(p_wdata),
    .periph_rdata(8'h5A), .flash_we(flash_we), .flash_waddr(flash_waddr),
    .flash_wdata(flash_wdata));
  mmd_properties #(.BIG(1'b1)) mmd_properties_i (.clk(clk), .reset(reset),
    .req(bus.req), .kind(bus.kind), .addr(bus.addr), .wdata(bus.wdata),
    .ack(bus.ack), .rdata(bus.rdata), .illegal(bus.illegal),
    .region(bus.region));
  always #12.5 clk = ~clk;
  // ****************************************
  // Link observers and shared tasks
  // ****************************************
  always @(posedge clk) begin
    if (bus.ack) begin
      reg_cap <= bus.region;
    end
    if (p_sel) begin
      ext_cap <= p_ext;
      we_cap <= p_we;
      wd_cap <= p_wdata;
      ad_cap <= p_addr;
    end
  end
  task automatic close_out();
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Done is a one-cycle pulse, so it is looked at on every falling edge.
  task automatic wait_done();
    int n;
    n = 0;
    @(negedge clk);
    acc_start = 1'b0;
    vec_start = 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: done got %h expected %h", $time, done, 1'b1);
      close_out();
    end
  endtask
  task automatic acc(input logic [1:0] k, input logic bk,
      input logic [19:0] a, input logic [7:0] wd, input logic [3:0] er);
    @(negedge clk);
    acc_kind = k;
    acc_banked = bk;
    acc_addr = a;
    acc_wdata = wd;
    acc_start = 1'b1;
    wait_done();
    cmp(reg_cap, er);
    cmp(illegal, er == 4'h0 || (er == 4'h6 && k != 2'h0) ||
      (er == 4'h8 && k == 2'h2));
  endtask
  task automatic load(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk);
    flash_we = 1'b1;
    flash_waddr = a;
    flash_wdata = d;
    @(negedge clk);
    flash_we = 1'b0;
  endtask
  task automatic set_bank(input logic [3:0] b);
    @(negedge clk);
    bank_we = 1'b1;
    bank_wdata = b;
    @(negedge clk);
    bank_we = 1'b0;
    cmp(bank_q, b);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_map();
    for (int i = 0; i < 22; i++) begin
      acc(2'h0, 1'b0, MAP[i][19:0], 8'h00, MAP[i][23:20]);
    end
    acc(2'h2, 1'b0, 20'hFFEF8, 8'h00, 4'h8);
    cmp(rdata, 8'h00);
  endtask
  task automatic t_mirror();
    load(13'h1FFF, 8'hA5);
    load(13'h0123, 8'h3C);
    acc(2'h0, 1'b0, 20'h01FFF, 8'h00, 4'h5);
    cmp(rdata, 8'hA5);
    acc(2'h0, 1'b0, 20'hF9FFF, 8'h00, 4'h6);
    cmp(rdata, 8'hA5);
    acc(2'h1, 1'b0, 20'hF8123, 8'h77, 4'h6);
    acc(2'h1, 1'b0, 20'h00123, 8'h77, 4'h5);
    acc(2'h2, 1'b0, 20'hF8123, 8'h00, 4'h6);
    cmp(rdata, 8'h00);
    acc(2'h0, 1'b0, 20'hF8123, 8'h00, 4'h6);
    cmp(rdata, 8'h3C);
  endtask
  task automatic t_ram();
    acc(2'h1, 1'b0, 20'hFFAE0, 8'h5C, 4'h7);
    acc(2'h1, 1'b0, 20'hFFEDF, 8'hC5, 4'h7);
    acc(2'h0, 1'b0, 20'hFFAE0, 8'h00, 4'h7);
    cmp(rdata, 8'h5C);
    acc(2'h2, 1'b0, 20'hFFEDF, 8'h00, 4'h7);
    cmp(rdata, 8'hC5);
  endtask
  task automatic t_bank();
    cmp(bank_q, 4'hF);
    acc(2'h0, 1'b1, 20'h0FF00, 8'h00, 4'h9);
    cmp(rdata, 8'h5A);
    cmp(ext_cap, 1'b0);
    cmp(ad_cap, 11'h700);
    acc(2'h1, 1'b1, 20'h00010, 8'h6E, 4'hA);
    cmp({ext_cap, we_cap, wd_cap}, 10'h36E);
    cmp(ad_cap, 11'h010);
    set_bank(4'h3);
    acc(2'h0, 1'b1, 20'h00123, 8'h00, 4'h0);
    cmp(rdata, 8'h00);
    set_bank(4'hF);
  endtask
  task automatic t_vec();
    logic [7:0] a;
    for (int s = 0; s < 4; s++) begin
      a = (s == 0) ? 8'h00 : (s == 1) ? 8'h04 : (s == 2) ? 8'h7E : 8'h0A;
      load({5'h00, a}, 8'h40 + a);
      load({5'h00, a} + 13'h0001, 8'hC0 + a);
      @(negedge clk);
      vec_src = s[1:0];
      vec_start = 1'b1;
      wait_done();
      cmp(vec_target, {4'h0, 8'hC0 + a, 8'h40 + a});
    end
  endtask
  // A reset in mid-run must bring the bank back to its default.
  task automatic t_reset();
    set_bank(4'h6);
    @(negedge clk);
    reset = 1'b1;
    @(negedge clk);
    cmp(bank_q, 4'hF);
    cmp(busy, 1'b0);
    cmp(vec_target, 20'h00000);
    reset = 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    cmp(busy, 1'b0);
    t_bank();
    t_mirror();
    t_ram();
    t_map();
    t_vec();
    t_reset();
    close_out();
  end
endmodule
